// ===== hw/dqh_conv_seq.v
// Purpose: sequences one a/d conversion from trigger to result capture
// Assumes: converter data is stable when done is raised
// Notes:   a trigger during a conversion is ignored
`timescale 1ns/1ps
`default_nettype none
`include "dqh_regs.vh"

module dqh_conv_seq (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        trig_i,
  input  wire [11:0] adc_data_i,
  output wire        adc_start_o,
  output wire        busy_o,
  output reg         done_o,
  output reg  [11:0] result_o
);
  // done rises a cycle before the count ends, so the ready flag behind it lands on the limit
  localparam integer LAST_N = `DQH_CONV_CYCLES - 2;
  localparam [8:0]   LAST   = LAST_N[8:0];
  reg       running;
  reg [8:0] count;

  assign adc_start_o = trig_i & ~running;
  assign busy_o      = running;

  always @(posedge clk_i) begin
    if (rst_i) begin
      running  <= 1'b0;
      count    <= 9'h000;
      done_o   <= 1'b0;
      result_o <= 12'h000;
    end else begin
      done_o <= 1'b0;
      if (adc_start_o) begin
        running <= 1'b1;
        count   <= 9'h000;
      end else if (running) begin
        if (count == LAST) begin
          running  <= 1'b0;
          done_o   <= 1'b1;
          result_o <= adc_data_i;
        end else begin
          count <= count + 9'h001;
        end
      end
    end
  end
endmodule // dqh_conv_seq
`default_nettype wire

// ===== hw/dqh_host_io.v
// Purpose: host register bank of a data acquisition card: a/d handoff, d/a, digital io
// Assumes: wishbone classic slave, byte data in bits 7:0, synchronous reset
// Notes:   ack one cycle after request, unmapped reads return zero and are acked
// Contract
// - mode register picks polled or interrupt handoff
// - reading result low byte clears ready
// - conversion finishes within 8 microseconds
// - interrupt at end of conversion, data valid
// - d/a low byte staged until high write
// - sixteen input and sixteen output lines
// - digital lines accessed as whole bytes
// - output lines 0-7 low, 8-15 high
// - ready flag low means result valid (status register bit 0 reads it active high)
// - interrupt flag cleared by write to 8
// - write to offset 12 starts conversion
// - d/a bits from offsets 4 and 5
`timescale 1ns/1ps
`default_nettype none
`include "dqh_regs.vh"

module dqh_host_io (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [5:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire [11:0] adc_data_i,
  output wire        adc_start_o,
  output reg         irq_o,
  output reg  [11:0] output_code_o,
  input  wire [15:0] sensed_lines_i,
  output reg  [15:0] output_lines_o
);
  reg  [7:0]  conversion_mode_control;
  reg  [7:0]  dac_stage;
  reg         result_ready_flag;
  reg         irq_status;
  reg  [7:0]  next_rdata;
  wire [3:0]  idx;
  wire        req;
  wire        wr;
  wire        rd;
  wire        lane0;
  wire        soft_trig;
  wire        conv_done;
  wire        conv_busy;
  wire [11:0] result;
  wire        irq_mode;
  wire        rd_result_lo;

  assign idx   = wb_adr_i[5:2];
  assign req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign lane0 = wb_sel_i[0];
  assign wr    = req & wb_we_i & lane0;
  assign rd    = req & ~wb_we_i;

  assign soft_trig    = wr & (idx == `DQH_IDX_SOFT_TRIG);
  assign irq_mode     = conversion_mode_control[`DQH_MODE_IRQ_BIT];
  assign rd_result_lo = rd & (idx == `DQH_IDX_RESULT_LO);

  dqh_conv_seq u_conv (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .trig_i      (soft_trig),
    .adc_data_i  (adc_data_i),
    .adc_start_o (adc_start_o),
    .busy_o      (conv_busy),
    .done_o      (conv_done),
    .result_o    (result)
  );

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  // read mux; ready is active low on the result high byte
  always @* begin
    next_rdata = 8'h00;
    case (idx)
      `DQH_IDX_RESULT_LO: next_rdata = result[7:0];
      `DQH_IDX_RESULT_HI: next_rdata = {3'b000, ~result_ready_flag, result[11:8]};
      `DQH_IDX_SENSED_LO: next_rdata = sensed_lines_i[7:0];
      `DQH_IDX_SENSED_HI: next_rdata = sensed_lines_i[15:8];
      `DQH_IDX_MODE:      next_rdata = conversion_mode_control;
      `DQH_IDX_OUT_LO:    next_rdata = output_lines_o[7:0];
      `DQH_IDX_OUT_HI:    next_rdata = output_lines_o[15:8];
      `DQH_IDX_STATUS:    next_rdata = {5'b00000, conv_busy, irq_status, result_ready_flag};
      default:            next_rdata = 8'h00;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (rd) begin
      wb_dat_o <= {24'h000000, next_rdata};
    end
  end

  // ready flag; a finishing conversion wins over a clearing read
  always @(posedge clk_i) begin
    if (rst_i) begin
      result_ready_flag <= 1'b0;
    end else if (conv_done) begin
      result_ready_flag <= 1'b1;
    end else if (rd_result_lo) begin
      result_ready_flag <= 1'b0;
    end
  end

  // interrupt status: set wins over the clearing write
  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_status <= 1'b0;
      irq_o      <= 1'b0;
    end else begin
      if (conv_done & irq_mode) begin
        irq_status <= 1'b1;
      end else if (wr & (idx == `DQH_IDX_IRQ_CLEAR)) begin
        irq_status <= 1'b0;
      end
      irq_o <= irq_status;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      conversion_mode_control <= `DQH_MODE_RESET;
      dac_stage               <= 8'h00;
      output_code_o           <= 12'h000;
      output_lines_o          <= 16'h0000;
    end else if (wr) begin
      case (idx)
        `DQH_IDX_RESULT_LO: dac_stage <= wb_dat_i[7:0];
        `DQH_IDX_RESULT_HI: output_code_o <= {wb_dat_i[3:0], dac_stage};
        `DQH_IDX_MODE:      conversion_mode_control <= wb_dat_i[7:0];
        `DQH_IDX_OUT_LO:    output_lines_o[7:0] <= wb_dat_i[7:0];
        `DQH_IDX_OUT_HI:    output_lines_o[15:8] <= wb_dat_i[7:0];
        default:            dac_stage <= dac_stage;
      endcase
    end
  end
endmodule // dqh_host_io
`default_nettype wire

// ===== hw/dqh_regs.vh
// Purpose: offsets, fields, reset values and timing counts of the host io block
// Assumes: classic wishbone, 32-bit data, one register per aligned word
// Notes:   printed offsets are indexes; byte address is four times the index
`ifndef DQH_REGS_VH
`define DQH_REGS_VH

`define DQH_IDX_RESULT_LO   4'h4
`define DQH_IDX_RESULT_HI   4'h5
`define DQH_IDX_SENSED_LO   4'h6
`define DQH_IDX_SENSED_HI   4'h7
`define DQH_IDX_IRQ_CLEAR   4'h8
`define DQH_IDX_MODE        4'hB
`define DQH_IDX_SOFT_TRIG   4'hC
`define DQH_IDX_OUT_LO      4'hD
`define DQH_IDX_OUT_HI      4'hE
`define DQH_IDX_STATUS      4'hF

`define DQH_MODE_RESET      8'h00
`define DQH_MODE_IRQ_BIT    0
`define DQH_READY_BIT       4
`define DQH_STAT_READY_BIT  0
`define DQH_STAT_IRQ_BIT    1
`define DQH_STAT_BUSY_BIT   2

`define DQH_CONV_TIME_NS    8000
`define DQH_CLK_PERIOD_NS   25
`define DQH_CONV_CYCLES     (`DQH_CONV_TIME_NS / `DQH_CLK_PERIOD_NS)

`endif

// ===== testbench/dqh_adc_model.sv
// Purpose: converter stand-in
// Assumes: data is sampled at end of conversion
// Notes: new code per start, held until the next
`timescale 1ns/1ps
`default_nettype none
module dqh_adc_model (
  input  wire logic        clk_i,
  input  wire logic        adc_start_i,
  output var  logic [11:0] adc_data_o
);
  logic [15:0] lf = 16'hACE1;
  initial adc_data_o = 12'h3C5;
  always @(posedge clk_i) if (adc_start_i) begin
    lf <= {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    adc_data_o <= lf[11:0];
  end
endmodule // dqh_adc_model
`default_nettype wire

// ===== testbench/dqh_monitor.sv
// Purpose: port checks of the host io block
// Assumes: ack one cycle after take
// Notes: irq lags conversion done by two cycles
`timescale 1ns/1ps
`default_nettype none
module dqh_monitor (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [5:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  input wire logic        adc_start_o,
  input wire logic        irq_o,
  input wire logic [11:0] output_code_o,
  input wire logic [15:0] output_lines_o
);
  wire        tk = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire        wr = tk & wb_we_i & wb_sel_i[0];
  wire  [3:0] ix = wb_adr_i[5:2];
  // saturates so a long idle never wraps into the window
  logic [9:0] age = 10'h000;
  always @(posedge clk_i) age <= adc_start_o ? 10'h000 : age + {9'h000, ~&age};
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_one_a: assert property (tk |=> wb_ack_o ##1 !wb_ack_o) else $error("ack not one pulse");
  trig_src_a: assert property (adc_start_o |-> wr && ix == 4'hC) else $error("stray start");
  out_lo_a: assert property (wr && ix == 4'hD |=> output_lines_o[7:0] == $past(wb_dat_i[7:0]))
    else $error("low port");
  out_hi_a: assert property (wr && ix == 4'hE |=> output_lines_o[15:8] == $past(wb_dat_i[7:0]))
    else $error("high port");
  dac_hold_a: assert property (wr && ix == 4'h4 |=> $stable(output_code_o)) else $error("code moved");
  dac_load_a: assert property (wr && ix == 4'h5 |=> output_code_o[11:8] == $past(wb_dat_i[3:0]))
    else $error("code high");
  conv_time_a: assert property ($rose(irq_o) |-> age >= 10'd319 && age <= 10'd322) else $error("late");
  irq_clr_a: assert property (wr && ix == 4'h8 |-> ##[2:3] !irq_o) else $error("irq kept");
  cover property (adc_start_o);
  cover property ($rose(irq_o));
  cover property (wr && ix == 4'h5);
endmodule // dqh_monitor
`default_nettype wire

// ===== testbench/tb_top.sv
// Purpose: self-checking bench of the host io block
// Assumes: ack one cycle after take
// Notes: results come from the converter model
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk_i = 1'h0, rst_i = 1'h1, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
  logic [5:0]  wb_adr_i = 6'h00;
  logic [3:0]  wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, rs = 32'h4F38;
  logic [15:0] sensed_lines_i = 16'h0;
  logic [11:0] ec = 12'h000;
  logic [7:0]  q;
  wire         wb_ack_o, adc_start_o, irq_o;
  wire  [31:0] wb_dat_o;
  wire  [11:0] adc_data_i, output_code_o;
  wire  [15:0] output_lines_o;
  int          err_total = 0, n_checks = 0;
  time         t0;
  always #12.5 clk_i = ~clk_i;
  dqh_host_io dut_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .adc_data_i, .adc_start_o, .irq_o, .output_code_o, .sensed_lines_i, .output_lines_o);
  dqh_adc_model adc_u (.clk_i, .adc_start_i(adc_start_o), .adc_data_o(adc_data_i));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic test_done;
    if (err_total == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one classic cycle; ack and read data are taken at the rising edge that sees ack high
  task automatic wb(input logic w, input logic [3:0] ix, input logic [7:0] d);
    int n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= w;
    wb_adr_i <= {ix, 2'h0};
    wb_dat_i <= {24'h000000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'h1 && n < 40);
    if (wb_ack_o !== 1'h1) begin
      err_total++;
      test_done;
    end else begin
      q = wb_dat_o[7:0];
      wb_cyc_i <= 1'h0;
      wb_stb_i <= 1'h0;
    end
  endtask
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'h0;
    wb(1'h0, 4'hF, 8'h00);
    chk(q & 8'h03, 8'h00);
    chk(output_code_o, ec);
    repeat (4) begin
      rs = xs(rs);
      sensed_lines_i <= rs[31:16];
      wb(1'h1, 4'h4, rs[7:0]);
      chk(output_code_o, ec);
      ec = rs[11:0];
      wb(1'h1, 4'h5, rs[15:8]);
      chk(output_code_o, ec);
      wb(1'h1, 4'hD, rs[7:0]);
      wb(1'h1, 4'hE, rs[15:8]);
      wb_sel_i <= 4'hE;
      wb(1'h1, 4'hD, rs[23:16]);
      wb_sel_i <= 4'hF;
      chk(output_lines_o, rs[15:0]);
      wb(1'h0, 4'h6, 8'h00);
      chk(q, rs[23:16]);
      wb(1'h0, 4'h7, 8'h00);
      chk(q, rs[31:24]);
      wb(1'h0, 4'h1, 8'h00);
      chk(q, 8'h00);
    end
    wb(1'h1, 4'hB, 8'h00);
    wb(1'h1, 4'hC, 8'h00);
    t0 = $time;
    wb(1'h0, 4'hF, 8'h00);
    chk(q[2:0], 3'h4);
    wb(1'h0, 4'h5, 8'h00);
    chk(q[4], 1'h1);
    repeat (200) if (q[4] !== 1'h0) wb(1'h0, 4'h5, 8'h00);
    chk(q[4], 1'h0);
    chk($time - t0 < 64'd8100, 1'h1);
    chk(q[3:0], adc_data_i[11:8]);
    wb(1'h0, 4'h4, 8'h00);
    chk(q, adc_data_i[7:0]);
    wb(1'h0, 4'h5, 8'h00);
    chk({q[4], irq_o}, 2'h2);
    wb(1'h1, 4'hB, 8'h01);
    wb(1'h0, 4'hB, 8'h00);
    chk(q, 8'h01);
    wb(1'h1, 4'hC, 8'h00);
    repeat (1000) @(negedge clk_i);
    chk(irq_o, 1'h1);
    wb(1'h0, 4'h4, 8'h00);
    chk(q, adc_data_i[7:0]);
    wb(1'h1, 4'h8, 8'h00);
    repeat (2) @(negedge clk_i);
    chk(irq_o, 1'h0);
    test_done;
  end
endmodule // tb_top
bind dqh_host_io dqh_monitor mon_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
  .wb_dat_i, .wb_ack_o, .adc_start_o, .irq_o, .output_code_o, .output_lines_o);
`default_nettype wire
